//--- dspmac_fabric.sv
// Fabric-side model presenting operands, selects and cascade values
`timescale 1ns/1ps
module dspmac_fabric (
	input  wire logic                         clock,      // Clock
	input  wire logic                         rst,        // Reset, high
	input  wire dspmac_pkg::dspmac_slice_in_s req_0,      // Next slice 0 word
	input  wire dspmac_pkg::dspmac_slice_in_s req_1,      // Next slice 1 word
	input  wire dspmac_pkg::dspmac_dyn_s      req_dyn,    // Next selects
	input  wire logic [53:0]                  req_cas,    // Next cascade
	input  wire logic [53:0]                  req_row,    // Next row cascade
	output dspmac_pkg::dspmac_slice_in_s      slice_in_0, // Slice 0 inputs
	output dspmac_pkg::dspmac_slice_in_s      slice_in_1, // Slice 1 inputs
	output dspmac_pkg::dspmac_dyn_s           dyn,        // Dynamic selects
	output logic [17:0]                       shift_in,   // Operand chain in
	output logic [53:0]                       cas_in,     // Cascade in
	output logic [53:0]                       row_cas_in  // Row cascade in
);
	// Selects and operands leave together on one edge
	always @(posedge clock) begin
		slice_in_0 <= req_0;
		slice_in_1 <= req_1;
		dyn <= req_dyn;
		cas_in <= req_cas;
		row_cas_in <= req_row;
		shift_in <= rst ? 18'h0 : shift_in + 18'h9; // Steps by 9 every cycle, held at 0 while rst is high
	end
endmodule : dspmac_fabric

//--- dspmac_pkg.sv
// Constants, types and register map of the dual-slice multiply-accumulate block
package dspmac_pkg;
	localparam int N_SL  = 2;               // Arithmetic slices
	localparam int W_OP  = 18;              // Operand width
	localparam int W_HLF = 9;               // Half operand width
	localparam int W_PRE = 20;              // Pre-adder width
	localparam int W_ACC = 54;              // Accumulator width
	localparam int W_M18 = W_PRE + W_OP;    // Pre-added product width
	localparam int W_M36 = W_PRE + 2 * W_OP; // Wide product width
	localparam int W_M9  = 2 * W_HLF + 1;   // Sum of two half products
	localparam int W_EXT = 64;              // Rounding work width
	localparam int W_SH  = 6;               // Round shift / saturation width fields
	localparam int W_AD  = 8;               // Decoded address bits
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_CFG    = 8'h04;
	localparam logic [7:0] OFF_STAT   = 8'h08;
	localparam logic [7:0] OFF_RES_LO = 8'h0c;
	localparam logic [7:0] OFF_RES_HI = 8'h10;
	// Control field positions
	localparam int B_ELEM = 0;              // Element type, 2 bits
	localparam int B_WID  = 2;              // Product width mode, 2 bits
	localparam int B_SYM  = 4;              // Pre-add mirrored samples
	localparam int B_NEG  = 5;              // Negative symmetry
	localparam int B_ODD  = 6;              // Odd tap count
	localparam int B_2D   = 7;              // Two-dimensional pre-add
	localparam int B_DYN  = 8;              // Selects come from fabric
	localparam int B_ROW  = 9;              // Cascade from next row
	localparam int B_RND  = 10;             // Rounding enable
	localparam int B_SAT  = 11;             // Saturation enable
	localparam int B_SUB  = 12;             // Static subtract
	// Configuration field positions
	localparam int B_RSH  = 0;              // Round shift
	localparam int B_SW   = 8;              // Saturation width
	// Reset values, NONSEQ transfer code and full saturation width
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] CFG_RST  = 32'h0000_3600;
	localparam logic [1:0]  HT_NSEQ  = 2'h2;
	localparam logic [5:0]  SW_FULL  = 6'h36;

	typedef enum logic [1:0] {
		EL_PLAIN_PLAIN_MULTIPLY_ELEMENT, EL_MAC, EL_ADDSUB, EL_ADDSUBSUM
	} dspmac_elem_e;
	typedef enum logic [1:0] {
		WD_18X18, WD_18X36, WD_9X9, WD_RSVD
	} dspmac_wid_e;
	typedef struct packed {
		logic [W_OP-1:0] a;               // Sample operand
		logic [W_OP-1:0] b;               // Coefficient operand
		logic [W_OP-1:0] c;               // Mirrored sample
		logic [W_OP-1:0] d;               // Second mirrored sample
		logic            load_shift;      // Shift from previous register
	} dspmac_slice_in_s;
	typedef struct packed {
		logic         add_sub;            // Subtract when high
		logic         acc_load;           // Start a fresh sum
		dspmac_elem_e elem;               // Element type this cycle
	} dspmac_dyn_s;
endpackage : dspmac_pkg

//--- dspmac_top.sv
// Dual-slice multiply, accumulate, add/subtract and sum block with AHB-Lite
// Summary of operation
// [RULE1] Two identical slices, joined or separate
// [RULE2] Multiply, accumulate, add/subtract, and summing elements
// [RULE3] Accumulate 18x36, two 18x18 or four 9x9
// [RULE4] Two 18x18 products summed into 54-bit accumulator
// [RULE5] Add or subtract chosen every cycle
// [RULE6] Operand loads parallel or shifts from previous
// [RULE7] Parallel or shift load chosen every cycle
// [RULE8] Synchronous reset, asynchronous as an option
// [RULE9] Dynamic selects change function each cycle
// [RULE10] Odd and even symmetric FIR pre-adding
// [RULE11] 2D symmetric pre-add, larger kernels cascade out
// [RULE12] Pipelined cascade paths, continuing between rows
// [RULE13] Configurable saturation and rounding of results
// [RULE14] Fabric presents selects with their operands
`timescale 1ns/1ps
module dspmac_top #(
	parameter bit ASYNC_RST = 1'b0              // Reset acts without clock
) (
	input  wire logic                         clock,      // 125 MHz clock
	input  wire logic                         rst,        // Reset, high
	input  wire logic                         dp_rst,     // Datapath reset
	input  wire dspmac_pkg::dspmac_slice_in_s slice_in_0, // Slice 0 inputs
	input  wire dspmac_pkg::dspmac_slice_in_s slice_in_1, // Slice 1 inputs
	input  wire dspmac_pkg::dspmac_dyn_s      dyn,        // Dynamic selects
	input  wire logic [17:0]                  shift_in,   // Operand chain in
	input  wire logic [53:0]                  cas_in,     // Adjacent cascade
	input  wire logic [53:0]                  row_cas_in, // Row cascade
	output logic      [17:0]                  shift_out,  // Operand chain out
	output logic      [53:0]                  cas_out,    // Cascade out
	output logic      [53:0]                  result,     // Final result
	input  wire logic                         hsel,       // Slave select
	input  wire logic [31:0]                  haddr,      // Address
	input  wire logic [1:0]                   htrans,     // Transfer type
	input  wire logic                         hwrite,     // Write
	input  wire logic [2:0]                   hsize,      // Size
	input  wire logic [31:0]                  hwdata,     // Write data
	input  wire logic                         hready,     // Bus ready
	output logic                              hreadyout,  // Slave ready
	output logic                              hresp,      // Always OKAY
	output logic      [31:0]                  hrdata      // Read data
);
	localparam int SL = dspmac_pkg::N_SL;
	localparam int WO = dspmac_pkg::W_OP;
	localparam int WH = dspmac_pkg::W_HLF;
	localparam int WP = dspmac_pkg::W_PRE;
	localparam int WA = dspmac_pkg::W_ACC;
	localparam int WX = dspmac_pkg::W_EXT;

	typedef struct packed {
		logic [31:0]            ctrl;
		logic [31:0]            cfg;
		logic                   sat_flag;
		logic [SL-1:0][WO-1:0]  a;
		logic [SL-1:0][WO-1:0]  b;
		logic [SL-1:0][WO-1:0]  c;
		logic [SL-1:0][WO-1:0]  d;
		dspmac_pkg::dspmac_dyn_s ctl1;
		dspmac_pkg::dspmac_dyn_s ctl2;
		logic [WA-1:0]          p0;
		logic [WA-1:0]          p1;
		logic [WA-1:0]          acc;
		logic [WA-1:0]          res;
		logic [WA-1:0]          cas;
		logic                   wr_pend;
		logic [7:0]             waddr;
		logic [31:0]            rdata;
		logic                   rdy;
	} dspmac_state_s;

	dspmac_state_s state_reg;
	dspmac_state_s state_next;

	dspmac_pkg::dspmac_slice_in_s  sin [SL];
	logic signed [WP-1:0]          pre [SL];
	logic signed [WA-1:0]          m18 [SL];
	logic signed [WA-1:0]          m9 [SL];
	logic signed [dspmac_pkg::W_M36-1:0] m36;
	dspmac_pkg::dspmac_wid_e       wid;

	assign sin[0] = slice_in_0;
	assign sin[1] = slice_in_1;
	assign wid = dspmac_pkg::dspmac_wid_e'(
		state_reg.ctrl[dspmac_pkg::B_WID +: 2]);

	////////////////////////////////////////////////////////////////////////
	// Per-slice pre-adder and multipliers
	for (genvar i = 0; i < SL; i++) begin : g_slice
		logic signed [WP-1:0]               ea;
		logic signed [WP-1:0]               ec;
		logic signed [WP-1:0]               ed;
		logic signed [dspmac_pkg::W_M18-1:0] mp;
		logic signed [2*WH-1:0]             ml;
		logic signed [2*WH-1:0]             mh;
		logic signed [dspmac_pkg::W_M9-1:0] ms;
		assign ea = WP'($signed(state_reg.a[i]));
		assign ec = WP'($signed(state_reg.c[i]));
		assign ed = WP'($signed(state_reg.d[i]));
		// Mirrored samples are folded before the multiply
		always_comb begin
			pre[i] = ea;
			if (state_reg.ctrl[dspmac_pkg::B_SYM] &&
			    !(state_reg.ctrl[dspmac_pkg::B_ODD] && i == SL - 1)) begin
				if (state_reg.ctrl[dspmac_pkg::B_NEG]) begin // see [RULE10]
					pre[i] = ea - ec;
				end else begin
					pre[i] = ea + ec;
				end
				if (state_reg.ctrl[dspmac_pkg::B_2D]) begin // see [RULE11]
					if (state_reg.ctrl[dspmac_pkg::B_NEG]) begin
						pre[i] = pre[i] - ed;
					end else begin
						pre[i] = pre[i] + ed;
					end
				end
			end
		end
		// Full and quarter size products, sign extended
		assign mp = pre[i] * $signed(state_reg.b[i]); // see [RULE3]
		assign ml = $signed(state_reg.a[i][WH-1:0]) *
			$signed(state_reg.b[i][WH-1:0]);
		assign mh = $signed(state_reg.a[i][WO-1:WH]) *
			$signed(state_reg.b[i][WO-1:WH]);
		assign ms = dspmac_pkg::W_M9'(ml) + dspmac_pkg::W_M9'(mh);
		assign m18[i] = WA'(mp);
		assign m9[i] = WA'(ms);
	end

	// Both slices join for the wide product
	assign m36 = pre[0] *
		$signed({state_reg.b[1], state_reg.b[0]}); // see [RULE1]

	////////////////////////////////////////////////////////////////////////
	// Next state: bus slave, operand stage, product stage, result stage
	always_comb begin
		logic                     dynm;
		logic                     sub;
		logic                     acc_new;
		dspmac_pkg::dspmac_elem_e el;
		logic [WA-1:0]            sum;
		logic [WA-1:0]            cin;
		logic [WA-1:0]            acc_v;
		logic signed [WX-1:0]     x;
		logic signed [WX-1:0]     mx;
		logic [5:0]               rsh;
		logic [5:0]               sw;
		logic                     clip;
		dynm = 1'b0;
		sub = 1'b0;
		acc_new = 1'b0;
		el = dspmac_pkg::EL_PLAIN_PLAIN_MULTIPLY_ELEMENT;
		sum = '0;
		cin = '0;
		acc_v = '0;
		x = '0;
		mx = '0;
		rsh = '0;
		sw = '0;
		clip = 1'b0;
		state_next = state_reg;

		// Register writes land in the data phase
		state_next.wr_pend = 1'b0;
		if (state_reg.wr_pend) begin
			if (state_reg.waddr == dspmac_pkg::OFF_CTRL) begin
				state_next.ctrl = hwdata;
			end else if (state_reg.waddr == dspmac_pkg::OFF_CFG) begin
				state_next.cfg = hwdata;
			end else if (state_reg.waddr == dspmac_pkg::OFF_STAT) begin
				state_next.sat_flag = state_reg.sat_flag & ~hwdata[0];
			end
		end
		// Address phase: latch writes, prepare read data
		state_next.rdata = '0;
		if (hsel && htrans == dspmac_pkg::HT_NSEQ && hready) begin
			state_next.wr_pend = hwrite;
			state_next.waddr = haddr[dspmac_pkg::W_AD-1:0];
			if (!hwrite) begin
				if (haddr[7:0] == dspmac_pkg::OFF_CTRL) begin
					state_next.rdata = state_reg.ctrl;
				end else if (haddr[7:0] == dspmac_pkg::OFF_CFG) begin
					state_next.rdata = state_reg.cfg;
				end else if (haddr[7:0] == dspmac_pkg::OFF_STAT) begin
					state_next.rdata = {30'h0, state_reg.res[WA-1],
						state_reg.sat_flag};
				end else if (haddr[7:0] == dspmac_pkg::OFF_RES_LO) begin
					state_next.rdata = state_reg.res[31:0];
				end else if (haddr[7:0] == dspmac_pkg::OFF_RES_HI) begin
					state_next.rdata = {10'h0, state_reg.res[WA-1:32]};
				end
			end
		end

		// Operand registers: parallel load or shift chain
		for (int i = 0; i < SL; i++) begin
			if (sin[i].load_shift) begin // see [RULE6] [RULE7]
				state_next.a[i] = (i == 0) ? shift_in : state_reg.a[i - 1];
			end else begin
				state_next.a[i] = sin[i].a;
			end
			state_next.b[i] = sin[i].b;
			state_next.c[i] = sin[i].c;
			state_next.d[i] = sin[i].d;
		end
		// Selects travel with the operands they govern
		state_next.ctl1 = dyn; // see [RULE14]
		state_next.ctl2 = state_reg.ctl1;

		// Product stage, combined by width mode
		if (wid == dspmac_pkg::WD_18X36) begin
			state_next.p0 = m36[WA-1:0];
			state_next.p1 = '0;
		end else if (wid == dspmac_pkg::WD_9X9) begin
			state_next.p0 = m9[0];
			state_next.p1 = m9[1];
		end else begin
			state_next.p0 = m18[0]; // see [RULE4]
			state_next.p1 = m18[1];
		end

		// Static or per-cycle function selection
		dynm = state_reg.ctrl[dspmac_pkg::B_DYN];
		if (dynm) begin // see [RULE9]
			el = state_reg.ctl2.elem;
			sub = state_reg.ctl2.add_sub; // see [RULE5]
			acc_new = state_reg.ctl2.acc_load;
		end else begin
			el = dspmac_pkg::dspmac_elem_e'(
				state_reg.ctrl[dspmac_pkg::B_ELEM +: 2]);
			sub = state_reg.ctrl[dspmac_pkg::B_SUB];
		end
		cin = state_reg.ctrl[dspmac_pkg::B_ROW] ?
			row_cas_in : cas_in; // see [RULE12]
		sum = sub ? state_reg.p0 - state_reg.p1 : state_reg.p0 + state_reg.p1;
		case (el) // see [RULE2]
			dspmac_pkg::EL_PLAIN_PLAIN_MULTIPLY_ELEMENT: begin
				acc_v = state_reg.p0;
			end
			dspmac_pkg::EL_MAC: begin
				acc_v = acc_new ? '0 : state_reg.acc; // see [RULE3]
				if (sub) begin
					acc_v = acc_v - (state_reg.p0 + state_reg.p1);
				end else begin
					acc_v = acc_v + (state_reg.p0 + state_reg.p1);
				end
			end
			dspmac_pkg::EL_ADDSUB: begin
				acc_v = sum;
			end
			default: begin
				acc_v = sum + cin; // see [RULE11] [RULE12]
			end
		endcase
		state_next.acc = acc_v;
		state_next.cas = state_reg.acc; // see [RULE12]

		// Rounding then saturation of the accumulated value
		x = WX'($signed(state_reg.acc));
		rsh = state_reg.cfg[dspmac_pkg::B_RSH +: dspmac_pkg::W_SH];
		sw = state_reg.cfg[dspmac_pkg::B_SW +: dspmac_pkg::W_SH];
		if (sw == 6'h00 || sw > dspmac_pkg::SW_FULL) begin
			sw = dspmac_pkg::SW_FULL;
		end
		if (state_reg.ctrl[dspmac_pkg::B_RND] && rsh != 6'h00) begin // see [RULE13]
			x = (x + (WX'(1) <<< (rsh - 6'h01))) >>> rsh;
		end
		mx = (WX'(1) <<< (sw - 6'h01)) - WX'(1);
		if (state_reg.ctrl[dspmac_pkg::B_SAT]) begin // see [RULE13]
			if (x > mx) begin
				x = mx;
				clip = 1'b1;
			end else if (x < -mx - WX'(1)) begin
				x = -mx - WX'(1);
				clip = 1'b1;
			end
		end
		state_next.res = x[WA-1:0];
		// Clipping wins over a clear in the same cycle
		if (clip) begin
			state_next.sat_flag = 1'b1;
		end

		// Fabric datapath reset clears the result and cascade registers but leaves CTRL, CFG and the saturation flag intact
		if (dp_rst) begin // see [RULE8]
			state_next.a = '0;
			state_next.b = '0;
			state_next.c = '0;
			state_next.d = '0;
			state_next.ctl1 = '0;
			state_next.ctl2 = '0;
			state_next.p0 = '0;
			state_next.p1 = '0;
			state_next.acc = '0;
			state_next.res = '0;
			state_next.cas = '0;
		end
		state_next.rdy = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// State register, synchronous reset or the asynchronous option
	// Reset branches load constants only, safe for the asynchronous option
	if (ASYNC_RST) begin : g_arst
		always_ff @(posedge clock or posedge rst) begin // see [RULE8]
			if (rst) begin
				state_reg <= '0;
				state_reg.ctrl <= dspmac_pkg::CTRL_RST;
				state_reg.cfg <= dspmac_pkg::CFG_RST;
				state_reg.rdy <= 1'b1;
			end else begin
				state_reg <= state_next;
			end
		end
	end else begin : g_srst
		always_ff @(posedge clock) begin // see [RULE8]
			if (rst) begin
				state_reg <= '0;
				state_reg.ctrl <= dspmac_pkg::CTRL_RST;
				state_reg.cfg <= dspmac_pkg::CFG_RST;
				state_reg.rdy <= 1'b1;
			end else begin
				state_reg <= state_next;
			end
		end
	end

	// Outputs straight from the state register, except hresp tied to OKAY
	assign shift_out = state_reg.a[SL-1];
	assign cas_out = state_reg.cas;
	assign result = state_reg.res;
	assign hreadyout = state_reg.rdy;
	assign hresp = 1'b0;
	assign hrdata = state_reg.rdata;
endmodule : dspmac_top

//--- dspmac_top_checker.sv
// Port-level assertions for the multiply-accumulate block
`timescale 1ns/1ps
module dspmac_top_checker (
	input wire logic                         clock,      // Clock
	input wire logic                         rst,        // Reset, high
	input wire logic                         dp_rst,     // Datapath reset
	input wire dspmac_pkg::dspmac_slice_in_s slice_in_0, // Slice 0 inputs
	input wire dspmac_pkg::dspmac_slice_in_s slice_in_1, // Slice 1 inputs
	input wire logic [17:0]                  shift_out,  // Operand chain out
	input wire logic [53:0]                  cas_out,    // Cascade out
	input wire logic [53:0]                  result,     // Final result
	input wire logic                         hsel,       // Slave select
	input wire logic [31:0]                  haddr,      // Address
	input wire logic [1:0]                   htrans,     // Transfer type
	input wire logic                         hwrite,     // Write
	input wire logic                         hready,     // Bus ready
	input wire logic                         hreadyout,  // Slave ready
	input wire logic                         hresp,      // Response
	input wire logic [31:0]                  hrdata      // Read data
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////
	// Read request accepted this cycle
	logic rd_take;
	assign rd_take = hsel && htrans == dspmac_pkg::HT_NSEQ && hready && !hwrite;
	// Slice 0 loads in parallel, then slice 1 shifts from it
	sequence s_chain_step;
		!dp_rst && !slice_in_0.load_shift ##1 !dp_rst && slice_in_1.load_shift;
	endsequence
	////////////////////////////////////////////////////////////////////////
	chk_shift_chain: assert property (
		s_chain_step |=> shift_out == $past(slice_in_0.a, 2))
		else $error("shift chain lost operand");
	chk_par_load: assert property (
		!dp_rst && !slice_in_1.load_shift |=> shift_out == $past(slice_in_1.a))
		else $error("parallel load wrong");
	chk_dp_clear: assert property (
		dp_rst [*4] |=> cas_out == 54'h0)
		else $error("datapath reset left cascade");
	chk_reset_state: assert property (
		$fell(rst) |-> hreadyout && hrdata == 32'h0 && result == 54'h0 &&
		cas_out == 54'h0)
		else $error("state not cleared by reset");
	chk_bus_okay: assert property (
		hsel |-> hresp == 1'b0)
		else $error("response not okay");
	chk_ready_high: assert property (
		hreadyout [*2])
		else $error("slave inserted wait");
	chk_rdata_idle: assert property (
		!rd_take |=> hrdata == 32'h0)
		else $error("read data outside data phase");
	chk_unmapped_rd: assert property (
		rd_take && haddr[7:0] > 8'h10 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
endmodule : dspmac_top_checker
bind dspmac_top dspmac_top_checker dspmac_top_checker_inst (.clock(clock),
	.rst(rst), .dp_rst(dp_rst), .slice_in_0(slice_in_0),
	.slice_in_1(slice_in_1), .shift_out(shift_out), .cas_out(cas_out),
	.result(result), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata));

//--- dspmac_top_tb.sv
// Self-checking bench for the multiply-accumulate block
`timescale 1ns/1ps
module dspmac_top_tb;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic dp_rst = 1'b0;
	dspmac_pkg::dspmac_slice_in_s r0 = '0, r1 = '0, s0, s1;
	dspmac_pkg::dspmac_dyn_s rd = '0, dy;
	logic [17:0] shin, shout;
	logic [53:0] rc = 54'd100, rr = 54'd200, cin, rin, cout, res;
	logic hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
	logic [1:0] htrans = 2'h0;
	int err_total = 0, checks = 0, cycles = 0;
	assign hready = hreadyout;
	////////////////////////////////////////////////////////////////////////
	dspmac_fabric dspmac_fabric_inst (.clock(clock), .rst(rst), .req_0(r0),
		.req_1(r1), .req_dyn(rd), .req_cas(rc), .req_row(rr),
		.slice_in_0(s0), .slice_in_1(s1), .dyn(dy), .shift_in(shin),
		.cas_in(cin), .row_cas_in(rin));
	dspmac_top dspmac_top_inst (.clock(clock), .rst(rst), .dp_rst(dp_rst),
		.slice_in_0(s0), .slice_in_1(s1), .dyn(dy), .shift_in(shin),
		.cas_in(cin), .row_cas_in(rin), .shift_out(shout), .cas_out(cout),
		.result(res), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
	////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	always #4 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			summarize();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task check(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task summarize();
		if (err_total == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize
	// One AHB-Lite single transfer; read data lands in rdv
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= dspmac_pkg::HT_NSEQ;
		hwrite <= wr;
		haddr <= {24'h0, a};
		@(posedge clock);
		while (hready !== 1'b1) @(posedge clock);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wr ? d : 32'h0;
		@(posedge clock);
		while (hready !== 1'b1) @(posedge clock);
		rdv = hrdata;
	endtask : bus
	// Configure, clear the pipeline, hold operands, compare the result
	task run(input logic [31:0] ctrl, input logic [31:0] cfg,
		input logic [17:0] a0, input logic [17:0] b0, input logic [17:0] c,
		input logic [17:0] a1, input logic [17:0] b1, input logic [53:0] exp);
		bus(1'b1, dspmac_pkg::OFF_CTRL, ctrl);
		bus(1'b1, dspmac_pkg::OFF_CFG, cfg);
		r0 <= '{a0, b0, c, c, 1'b0};
		r1 <= '{a1, b1, c, c, 1'b0};
		dp_rst <= 1'b1;
		repeat (5) @(posedge clock);
		dp_rst <= 1'b0;
		repeat (8) @(posedge clock);
		check(res, exp);
	endtask : run
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		bus(1'b0, dspmac_pkg::OFF_CTRL, 32'h0);
		check(rdv, 32'h0);
		bus(1'b0, dspmac_pkg::OFF_CFG, 32'h0);
		check(rdv, 32'h3600);
		bus(1'b1, 8'h14, 32'hffff_ffff);
		bus(1'b0, 8'h14, 32'h0);
		check(rdv, 32'h0);
		bus(1'b1, dspmac_pkg::OFF_CTRL, 32'h1fff);
		bus(1'b0, dspmac_pkg::OFF_CTRL, 32'h0);
		check(rdv, 32'h1fff);
		run(32'h0, 32'h3600, 3, 5, 0, 0, 0, 54'd15);
		// Static accumulate: four products summed by the check edge
		run(32'h1, 32'h3600, 3, 5, 0, 0, 0, 54'd60);
		run(32'h2, 32'h3600, 7, 6, 0, 2, 4, 54'd50);
		run(32'h1002, 32'h3600, 7, 6, 0, 2, 4, 54'd34);
		run(32'h2, 32'h3600, 18'h1ffff, 18'h1ffff, 0, 18'h1ffff, 18'h1ffff,
			54'h7_fff8_0002);
		bus(1'b0, dspmac_pkg::OFF_RES_LO, 32'h0);
		check(rdv, 32'hfff8_0002);
		bus(1'b0, dspmac_pkg::OFF_RES_HI, 32'h0);
		check(rdv, 32'h7);
		run(32'ha, 32'h3600, {9'd2, 9'd3}, {9'd4, 9'd5}, 0, {9'd1, 9'd1},
			{9'd1, 9'd2}, 54'd26);
		run(32'h4, 32'h3600, 3, 0, 0, 0, 1, 54'hc_0000);
		run(32'h10, 32'h3600, 4, 2, 3, 0, 0, 54'd14);
		run(32'h30, 32'h3600, 4, 2, 3, 0, 0, 54'd2);
		run(32'h52, 32'h3600, 4, 1, 3, 2, 1, 54'd9);
		run(32'h92, 32'h3600, 4, 1, 3, 0, 0, 54'd10);
		run(32'h400, 32'h3602, 3, 5, 0, 0, 0, 54'd4);
		run(32'h800, 32'h0400, 3, 5, 0, 0, 0, 54'd7);
		bus(1'b0, dspmac_pkg::OFF_STAT, 32'h0);
		check(rdv & 32'h3, 32'h1);
		run(32'h3, 32'h3600, 1, 1, 0, 0, 0, 54'd101);
		check(cout, 54'd101);
		run(32'h203, 32'h3600, 1, 1, 0, 0, 0, 54'd201);
		// Fabric-driven accumulate: load, add three times, subtract once
		run(32'h100, 32'h3600, 0, 0, 0, 0, 0, 54'd0);
		r0 <= '{18'd2, 18'd5, 18'h0, 18'h0, 1'b0};
		rd <= '{1'b0, 1'b1, dspmac_pkg::EL_MAC};
		@(posedge clock);
		rd <= '{1'b0, 1'b0, dspmac_pkg::EL_MAC};
		repeat (3) @(posedge clock);
		rd <= '{1'b1, 1'b0, dspmac_pkg::EL_MAC};
		@(posedge clock);
		r0 <= '0;
		rd <= '{1'b0, 1'b0, dspmac_pkg::EL_MAC};
		repeat (8) @(posedge clock);
		check(res, 54'd30);
		// Operand loading switched every cycle
		for (int i = 0; i < 6; i++) begin
			r0 <= '{18'(i + 1), 18'h0, 18'h0, 18'h0, i[1]};
			r1 <= '{18'h3, 18'h0, 18'h0, 18'h0, i[0]};
			@(posedge clock);
		end
		r0 <= '{18'h15, 18'h0, 18'h0, 18'h0, 1'b0};
		r1 <= '{18'h3, 18'h0, 18'h0, 18'h0, 1'b1};
		repeat (4) @(posedge clock);
		check(shout, 18'h15);
		summarize();
	end
endmodule : dspmac_top_tb
